// File: hw/uvidmt_stage.sv
// Undervoltage inverse-time stage with selectable magnitude front end and
// an Avalon-MM register slave. Samples arrive on sys_clk with a valid strobe.
// Overview of operation
// - A magnitude below the threshold raises start and begins integration in that evaluation.
// - Operate rises once the integrator sum, gaining cycle time over operate time per evaluation, reaches one.
// - The time multiplier scales the curve as factor k on its leading term.
// - The inverse operate time is never shorter than the minimum operate time.
// - Operate time is k*A over (B*(thr-u)/thr - C) to the power E, plus D.
// - Curve A uses 1,1,0,0,1 and curve B uses 480,32,0.5,0.055,2 for A to E.
// - The user curve takes A to E from five coefficient settings.
// - Within the saturation band below threshold the formula uses thr*(1-sat/100).
// - The standard curves, A included, use a saturation of 2.0 percent.
// - A mode setting picks RMS, DFT, peak-to-peak or peak-to-peak with peak fallback.
// - RMS mode takes the root of the mean of squared samples over one cycle, DC kept.
// - DFT mode extracts the fundamental, rejecting harmonics 2 to 5 deeply.
// - Peak-to-peak mode averages the positive and negative peaks, DC excluded.
// - Fallback mode also starts when the single peak exceeds twice the threshold.
// - The peak fallback works only in definite-time mode as a high stage.
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uvidmt_defs.svh"
module uvidmt_stage (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic signed [15:0] sample,
   input wire logic sample_valid,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic start,
   output logic operate
);
   uvidmt_pkg::uvidmt_core_t s;
   uvidmt_pkg::uvidmt_core_t n;

   function automatic logic signed [15:0] cos_q15(input logic [3:0] i);
      logic [3:0] f;
      logic [3:0] g;
      logic [15:0] m;
      f = i[3] ? 4'(5'h10 - {1'b0, i}) : i;
      g = (f > 4'h4) ? 4'(4'h8 - f) : f;
      case (g)
         4'h0: m = 16'h7fff;
         4'h1: m = 16'h7642;
         4'h2: m = 16'h5a82;
         4'h3: m = 16'h30fc;
         default: m = 16'h0000;
      endcase
      return (f > 4'h4) ? 16'(-m) : m;
   endfunction : cos_q15

   function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] w,
      input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++)
         if (be[b])
            r[8*b+:8] = w[8*b+:8];
      return r;
   endfunction : be_merge

   logic first;
   logic signed [15:0] cv;
   logic signed [15:0] sv;
   logic signed [31:0] pr_sq;
   logic signed [31:0] pr_re;
   logic signed [31:0] pr_im;
   logic [35:0] f_sq;
   logic [35:0] f_re;
   logic [35:0] f_im;
   logic signed [15:0] f_max;
   logic signed [15:0] f_min;
   logic [15:0] pp;
   logic [16:0] pk;
   logic signed [17:0] re_s;
   logic signed [17:0] im_s;
   logic [63:0] rad;
   uvidmt_pkg::uvidmt_mode_t mode;
   uvidmt_pkg::uvidmt_curve_t curve;
   logic std;
   logic below;
   logic bk_act;
   logic run;
   logic [15:0] sat_eff;
   logic [31:0] rlim;
   logic [31:0] ca;
   logic [31:0] cb;
   logic [31:0] cc;
   logic [31:0] cd;
   logic [31:0] ce;
   logic [1:0] e_eff;
   logic [63:0] bx;
   logic [48:0] xf;
   logic xpos;
   logic [31:0] xv;
   logic [63:0] pm;
   logic [47:0] ka;
   logic [32:0] td;
   logic [31:0] tl;
   logic [31:0] tcl;
   logic [33:0] asum;
   logic [31:0] rd_mux;
   logic [31:0] alu_res;
   logic alu_done;

   // One calculation cycle is sixteen samples; a full-cycle DFT over it nulls
   // DC and every integer harmonic from the second to the fourteenth.
   assign first = s.idx == 4'h0;
   assign cv = cos_q15(s.idx);
   assign sv = cos_q15(4'(s.idx - 4'h4));
   assign pr_sq = sample * sample;
   assign pr_re = sample * cv;
   assign pr_im = sample * sv;
   assign f_sq = (first ? 36'h0 : s.sq) + {4'h0, pr_sq};
   assign f_re = (first ? 36'h0 : s.re) + 36'(pr_re);
   assign f_im = (first ? 36'h0 : s.im) + 36'(pr_im);
   assign f_max = (first || sample > $signed(s.vmax)) ? sample : $signed(s.vmax);
   assign f_min = (first || sample < $signed(s.vmin)) ? sample : $signed(s.vmin);
   assign pp = 16'((17'(f_max) - 17'(f_min)) >> 1);
   assign pk = (f_max > -f_min) ? 17'(f_max) : 17'(-17'(f_min));
   assign re_s = 18'($signed(f_re) >>> 18);
   assign im_s = 18'($signed(f_im) >>> 18);
   assign mode = uvidmt_pkg::uvidmt_mode_t'(s.ctrl[1:0]);
   assign curve = uvidmt_pkg::uvidmt_curve_t'(s.ctrl[3:2]);

   always_comb
   begin
      case (mode)
         uvidmt_pkg::m_rms: rad = 64'(f_sq >> 4);
         uvidmt_pkg::m_dft: rad = 64'(re_s * re_s) + 64'(im_s * im_s);
         default: rad = 64'(pp) * 64'(pp);
      endcase
   end

   assign std = (curve == uvidmt_pkg::c_inv_a) || (curve == uvidmt_pkg::c_inv_b);
   assign sat_eff = std ? `UVI_SAT_STD : s.sat;
   assign rlim = ({16'h0, sat_eff} << 8) / `UVI_PCT;
   assign ca = (curve == uvidmt_pkg::c_inv_a) ? `UVI_A_CA :
      (curve == uvidmt_pkg::c_inv_b) ? `UVI_B_CA : s.coef[0];
   assign cb = (curve == uvidmt_pkg::c_inv_a) ? `UVI_A_CB :
      (curve == uvidmt_pkg::c_inv_b) ? `UVI_B_CB : s.coef[1];
   assign cc = (curve == uvidmt_pkg::c_inv_a) ? `UVI_A_CC :
      (curve == uvidmt_pkg::c_inv_b) ? `UVI_B_CC : s.coef[2];
   assign cd = (curve == uvidmt_pkg::c_inv_a) ? `UVI_A_CD :
      (curve == uvidmt_pkg::c_inv_b) ? `UVI_B_CD : s.coef[3];
   assign ce = (curve == uvidmt_pkg::c_inv_a) ? `UVI_A_CE :
      (curve == uvidmt_pkg::c_inv_b) ? `UVI_B_CE : s.coef[4];
   assign e_eff = |ce[31:2] ? 2'h3 : ce[1:0];

   assign below = s.mag < s.thr;
   assign bk_act = (mode == uvidmt_pkg::m_peak_pair_with_peak_fallback) &&
      s.ctrl[`UVI_CTRL_DT] && s.ctrl[`UVI_CTRL_HIGH];
   assign run = s.ctrl[`UVI_CTRL_EN] && (below || (bk_act && s.bkp));

   // Curve denominator base B*ratio - C in Q16.16; zero or less gives no time.
   assign bx = cb * s.ratio;
   assign xf = {1'b0, bx[63:16]} - {17'h0, cc};
   assign xpos = !xf[48] && (xf != 49'h0);
   assign xv = |xf[47:32] ? 32'hffffffff : xf[31:0];
   assign pm = s.pw * xv;
   assign ka = s.tmult * ca;
   assign td = {1'b0, alu_res} + {1'b0, cd};
   assign tl = td[32] ? 32'hffffffff : td[31:0];
   assign tcl = (tl < s.tmin) ? s.tmin : tl;
   assign asum = {1'b0, s.acc} + {2'h0, alu_res};

   always_comb
   begin
      rd_mux = 32'h0;
      if (avs_address == `UVI_OFS_CTRL)
         rd_mux = {25'h0, s.ctrl};
      if (avs_address == `UVI_OFS_THR)
         rd_mux = {16'h0, s.thr};
      if (avs_address == `UVI_OFS_TMULT)
         rd_mux = {16'h0, s.tmult};
      if (avs_address == `UVI_OFS_TMIN)
         rd_mux = s.tmin;
      if (avs_address == `UVI_OFS_SAT)
         rd_mux = {16'h0, s.sat};
      for (int i = 0; i < 5; i++)
         if (avs_address == 6'(`UVI_OFS_CA + 6'(4 * i)))
            rd_mux = s.coef[i];
      if (avs_address == `UVI_OFS_STATUS)
         rd_mux = {s.mag, 13'h0, s.state != uvidmt_pkg::s_idle, s.operate, s.start};
   end

   always_comb
   begin
      n = s;
      n.go = 1'b0;
      // One wait state: a write is taken on the edge where waitrequest is low; read data is captured on the edge before.
      n.wt = !((avs_read || avs_write) && s.wt);
      if (avs_read && s.wt)
         n.rdata = rd_mux;
      if (avs_write && !s.wt)
      begin
         if (avs_address == `UVI_OFS_CTRL)
            n.ctrl = 7'(be_merge({25'h0, s.ctrl}, avs_writedata, avs_byteenable));
         if (avs_address == `UVI_OFS_THR)
            n.thr = 16'(be_merge({16'h0, s.thr}, avs_writedata, avs_byteenable));
         if (avs_address == `UVI_OFS_TMULT)
            n.tmult = 16'(be_merge({16'h0, s.tmult}, avs_writedata, avs_byteenable));
         if (avs_address == `UVI_OFS_TMIN)
            n.tmin = be_merge(s.tmin, avs_writedata, avs_byteenable);
         if (avs_address == `UVI_OFS_SAT)
            n.sat = 16'(be_merge({16'h0, s.sat}, avs_writedata, avs_byteenable));
         for (int i = 0; i < 5; i++)
            if (avs_address == 6'(`UVI_OFS_CA + 6'(4 * i)))
               n.coef[i] = be_merge(s.coef[i], avs_writedata, avs_byteenable);
      end
      if (sample_valid)
      begin
         n.idx = 4'(s.idx + 4'h1);
         n.sq = f_sq;
         n.re = f_re;
         n.im = f_im;
         n.vmax = f_max;
         n.vmin = f_min;
         if (s.idx == `UVI_LAST_IDX)
            n.bkp = pk > {s.thr, 1'b0};
      end
      case (s.state)
         uvidmt_pkg::s_idle:
            if (sample_valid && s.idx == `UVI_LAST_IDX)
            begin
               n.go = 1'b1;
               n.op = 1'b1;
               n.num = rad;
               n.state = uvidmt_pkg::s_root;
            end
         uvidmt_pkg::s_root:
            if (alu_done)
            begin
               n.mag = |alu_res[31:16] ? 16'hffff : alu_res[15:0];
               n.state = uvidmt_pkg::s_eval;
            end
         uvidmt_pkg::s_eval:
            if (!run)
            begin
               n.start = 1'b0;
               n.operate = 1'b0;
               n.acc = 33'h0;
               n.state = uvidmt_pkg::s_idle;
            end
            else
            begin
               n.start = 1'b1;
               n.go = 1'b1;
               n.op = 1'b0;
               if (s.ctrl[`UVI_CTRL_DT])
               begin
                  n.tq = s.tmin;
                  n.num = {`UVI_CYCLE_Q16, 32'h0};
                  n.den = s.tmin;
                  n.state = uvidmt_pkg::s_incr;
               end
               else
               begin
                  n.num = {32'h0, below ? 16'(s.thr - s.mag) : 16'h0, 16'h0};
                  n.den = {16'h0, s.thr};
                  n.state = uvidmt_pkg::s_ratio;
               end
            end
         uvidmt_pkg::s_ratio:
            if (alu_done)
            begin
               n.ratio = (alu_res < rlim) ? rlim : alu_res;
               n.pw = `UVI_ONE_Q16;
               n.ecnt = 2'h0;
               n.state = uvidmt_pkg::s_power;
            end
         uvidmt_pkg::s_power:
            if (!xpos)
               n.state = uvidmt_pkg::s_idle;
            else if (s.ecnt < e_eff)
            begin
               n.pw = |pm[63:48] ? 32'hffffffff : pm[47:16];
               n.ecnt = 2'(s.ecnt + 2'h1);
            end
            else
            begin
               n.go = 1'b1;
               n.op = 1'b0;
               n.num = {8'h0, ka, 8'h0};
               n.den = s.pw;
               n.state = uvidmt_pkg::s_quot;
            end
         uvidmt_pkg::s_quot:
            if (alu_done)
            begin
               n.tq = tcl;
               n.go = 1'b1;
               n.op = 1'b0;
               n.num = {`UVI_CYCLE_Q16, 32'h0};
               n.den = tcl;
               n.state = uvidmt_pkg::s_incr;
            end
         uvidmt_pkg::s_incr:
            if (alu_done)
            begin
               if (asum[33:32] != 2'h0)
               begin
                  n.acc = {1'b1, 32'h0};
                  n.operate = 1'b1;
               end
               else
                  n.acc = asum[32:0];
               n.state = uvidmt_pkg::s_idle;
            end
         default:
            n.state = uvidmt_pkg::s_idle;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         s <= '0;
         s.state <= uvidmt_pkg::s_idle;
         s.wt <= 1'b1;
         s.ctrl <= `UVI_RST_CTRL;
         s.thr <= `UVI_RST_THR;
         s.tmult <= `UVI_RST_TMULT;
         s.tmin <= `UVI_RST_TMIN;
         s.sat <= `UVI_SAT_STD;
         s.coef <= {`UVI_A_CE, `UVI_A_CD, `UVI_A_CC, `UVI_A_CB, `UVI_A_CA};
      end
      else
         s <= n;
   end

   uvidmt_seqalu u_alu (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .go(s.go),
      .op(s.op),
      .num(s.num),
      .den(s.den),
      .result(alu_res),
      .done(alu_done)
   );

   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.wt;
   assign start = s.start;
   assign operate = s.operate;

   default clocking cb_sys @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_cycle_end;
      sample_valid && s.idx == `UVI_LAST_IDX && s.state == uvidmt_pkg::s_idle;
   endsequence
   sequence s_root_wait;
      s.state == uvidmt_pkg::s_root [*8];
   endsequence

   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest not dropped");
   a_mag_path: assert property (s_cycle_end |=> s_root_wait)
      else $error("magnitude not computed");
   a_start_eval: assert property (s.state == uvidmt_pkg::s_eval && run |=> start)
      else $error("start missing below threshold");
   a_operate_start: assert property (operate |-> start)
      else $error("operate without start");
   a_recover_clear: assert property (s.state == uvidmt_pkg::s_eval && !run
      |=> !start && !operate && s.acc == 33'h0) else $error("integrator not cleared");
   a_min_time: assert property (s.state == uvidmt_pkg::s_quot && alu_done
      |=> s.tq >= s.tmin && s.state == uvidmt_pkg::s_incr) else $error("time below minimum");
   a_sat_floor: assert property (s.state == uvidmt_pkg::s_power |-> s.ratio >= rlim)
      else $error("ratio under saturation floor");
   a_std_sat: assert property (std |-> rlim == 32'h0000051e)
      else $error("standard saturation wrong");
   a_fallback_gate: assert property (s.state == uvidmt_pkg::s_eval && !below && !bk_act
      |=> !start) else $error("fallback start outside high stage");
   a_operate_one: assert property (s.state == uvidmt_pkg::s_incr && alu_done
      && asum >= 34'h100000000 |=> operate && s.acc == 33'h100000000)
      else $error("operate missed at one");
endmodule : uvidmt_stage
`default_nettype wire

// File: common/uvidmt_defs.svh
// Offsets, field positions, reset values and fixed curve figures of the
// undervoltage inverse-time stage. Definitions only.
`ifndef UVIDMT_DEFS_SVH
`define UVIDMT_DEFS_SVH
`define UVI_OFS_CTRL 6'h00
`define UVI_OFS_THR 6'h04
`define UVI_OFS_TMULT 6'h08
`define UVI_OFS_TMIN 6'h0c
`define UVI_OFS_SAT 6'h10
`define UVI_OFS_CA 6'h14
`define UVI_OFS_STATUS 6'h28
`define UVI_CTRL_EN 4
`define UVI_CTRL_DT 5
`define UVI_CTRL_HIGH 6
`define UVI_RST_CTRL 7'h11
`define UVI_RST_THR 16'h4000
`define UVI_RST_TMULT 16'h0100
`define UVI_RST_TMIN 32'h00000000
`define UVI_SAT_STD 16'h0200
`define UVI_PCT 32'h00000064
`define UVI_ONE_Q16 32'h00010000
`define UVI_LAST_IDX 4'hf
`define UVI_A_CA 32'h00010000
`define UVI_A_CB 32'h00010000
`define UVI_A_CC 32'h00000000
`define UVI_A_CD 32'h00000000
`define UVI_A_CE 32'h00000001
`define UVI_B_CA 32'h01e00000
`define UVI_B_CB 32'h00200000
`define UVI_B_CC 32'h00008000
`define UVI_B_CD 32'h00000e14
`define UVI_B_CE 32'h00000002
`define UVI_CYCLE_US 64'h0000000000004e20
`define UVI_US_PER_S 64'h00000000000f4240
`define UVI_CYCLE_Q16 32'((`UVI_CYCLE_US * 64'h0000000000010000) / `UVI_US_PER_S)
`endif

// File: common/uvidmt_pkg.sv
// Types of the undervoltage inverse-time stage.
// Assumes nothing of its surroundings.
`default_nettype none
package uvidmt_pkg;
   typedef enum logic [1:0] {m_rms = 2'h0, m_dft = 2'h1, m_peak_pair = 2'h2,
      m_peak_pair_with_peak_fallback = 2'h3} uvidmt_mode_t;
   typedef enum logic [1:0] {c_inv_a = 2'h0, c_inv_b = 2'h1, c_user = 2'h2} uvidmt_curve_t;
   typedef enum logic [6:0] {s_idle = 7'h01, s_root = 7'h02, s_eval = 7'h04,
      s_ratio = 7'h08, s_power = 7'h10, s_quot = 7'h20, s_incr = 7'h40} uvidmt_state_t;
   typedef struct packed {
      logic busy;
      logic sq;
      logic [6:0] cnt;
      logic [63:0] src;
      logic [35:0] rem;
      logic [63:0] res;
      logic [31:0] den;
      logic [31:0] out;
      logic done;
   } uvidmt_alu_t;
   typedef struct packed {
      uvidmt_state_t state;
      logic wt;
      logic [31:0] rdata;
      logic [6:0] ctrl;
      logic [15:0] thr;
      logic [15:0] tmult;
      logic [31:0] tmin;
      logic [15:0] sat;
      logic [4:0][31:0] coef;
      logic [3:0] idx;
      logic [35:0] sq;
      logic [35:0] re;
      logic [35:0] im;
      logic [15:0] vmax;
      logic [15:0] vmin;
      logic bkp;
      logic [15:0] mag;
      logic [31:0] ratio;
      logic [31:0] pw;
      logic [1:0] ecnt;
      logic [31:0] tq;
      logic [32:0] acc;
      logic start;
      logic operate;
      logic go;
      logic op;
      logic [63:0] num;
      logic [31:0] den;
   } uvidmt_core_t;
endpackage : uvidmt_pkg
`default_nettype wire

// File: hw/uvidmt_seqalu.sv
// Sequential unsigned divider and square root, one bit per clock.
// Assumes go is a one-cycle pulse given only while the unit is idle.
`timescale 1ns/1ps
`default_nettype none
module uvidmt_seqalu (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic go,
   input wire logic op,
   input wire logic [63:0] num,
   input wire logic [31:0] den,
   output logic [31:0] result,
   output logic done
);
   uvidmt_pkg::uvidmt_alu_t s;
   uvidmt_pkg::uvidmt_alu_t n;
   logic [35:0] rt;
   logic [35:0] trial;

   // Division gives num/den saturated to 32 bits; op high gives floor(sqrt(num)).
   always_comb
   begin
      n = s;
      n.done = 1'b0;
      rt = s.sq ? {s.rem[33:0], s.src[63:62]} : {s.rem[34:0], s.src[63]};
      trial = s.sq ? {2'h0, s.res[31:0], 2'h1} : {4'h0, s.den};
      if (!s.busy)
      begin
         if (go)
         begin
            n.busy = 1'b1;
            n.sq = op;
            n.cnt = op ? 7'h20 : 7'h40;
            n.src = num;
            n.den = den;
            n.rem = 36'h0;
            n.res = 64'h0;
         end
      end
      else
      begin
         n.src = s.sq ? {s.src[61:0], 2'h0} : {s.src[62:0], 1'h0};
         n.rem = (rt >= trial) ? 36'(rt - trial) : rt;
         n.res = {s.res[62:0], rt >= trial};
         n.cnt = 7'(s.cnt - 7'h01);
         if (s.cnt == 7'h01)
         begin
            n.busy = 1'b0;
            n.done = 1'b1;
            n.out = |n.res[63:32] ? 32'hffffffff : n.res[31:0];
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         s <= '0;
      else
         s <= n;
   end

   assign result = s.out;
   assign done = s.done;

   // The answer is registered with the last step; loading takes one edge, so done comes 33 or 65 edges after go.
   a_alu_latency: assert property (@(posedge sys_clk) disable iff (!rst_b)
      go && !s.busy |-> ##[33:65] done) else $error("alu answer late");
   a_alu_root: assert property (@(posedge sys_clk) disable iff (!rst_b)
      go && !s.busy && op |-> ##33 done && 64'(result) * 64'(result) <= $past(num, 33))
      else $error("square root too large");
endmodule : uvidmt_seqalu
`default_nettype wire

// File: tb/uvidmt_src.sv
// Sample source model: sends one calculation cycle of 16 samples per burst.
// Assumes burst is a one-cycle pulse given only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module uvidmt_src #(parameter int GAP = 20) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic burst,
   input wire logic signed [15:0] dc,
   input wire logic signed [15:0] amp,
   input wire logic signed [15:0] hamp,
   output logic signed [15:0] sample,
   output logic sample_valid,
   output logic busy
);
   localparam int TAB[16] = '{0, 392, 724, 946, 1024, 946, 724, 392,
      0, -392, -724, -946, -1024, -946, -724, -392};
   int n;
   int w;
   // Between samples the line toggles, so a stale value is never mistaken for data.
   always_ff @(posedge sys_clk)
   begin
      sample_valid <= 1'b0;
      sample <= ~sample;
      if (!rst_b)
      begin
         sample <= 16'h5a5a;
         busy <= 1'b0;
         n <= 0;
         w <= 0;
      end
      else if (burst && !busy)
      begin
         busy <= 1'b1;
         n <= 0;
         w <= GAP;
      end
      else if (busy && w == 0)
      begin
         sample <= 16'(dc + (amp * TAB[n] + hamp * TAB[(3 * n) % 16]) / 1024);
         sample_valid <= 1'b1;
         n <= n + 1;
         w <= GAP;
         busy <= (n != 15);
      end
      else if (busy)
         w <= w - 1;
   end
endmodule : uvidmt_src
`default_nettype wire

// File: tb/uvidmt_stage_tb.sv
// Testbench of the undervoltage inverse-time stage, fed by the sample source model.
// Assumes the stage ends every bus access by dropping waitrequest for one edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module uvidmt_stage_tb;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic burst = 1'b0;
   logic signed [15:0] dc = 16'h0000;
   logic signed [15:0] amp = 16'h0000;
   logic signed [15:0] hamp = 16'h0000;
   logic signed [15:0] sample;
   logic sample_valid;
   logic busy;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic start;
   logic operate;
   logic [31:0] rdata;
   int n_fail = 0;
   int tests_run = 0;
   uvidmt_stage i_uvidmt_stage (.sys_clk(sys_clk), .rst_b(rst_b), .sample(sample),
      .sample_valid(sample_valid), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .start(start), .operate(operate));
   uvidmt_src i_uvidmt_src (.sys_clk(sys_clk), .rst_b(rst_b), .burst(burst), .dc(dc),
      .amp(amp), .hamp(hamp), .sample(sample), .sample_valid(sample_valid), .busy(busy));
   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic hang(input string nm);
      n_fail++;
      $display("ERROR %s expected done seen timeout", nm);
      tally_and_finish();
   endtask : hang
   // The request is held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      do
      begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0)
         hang("bus");
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask : wr
   task automatic rd(input logic [5:0] a);
      bus(1'b0, a, 32'h00000000, 4'hf);
   endtask : rd
   // One calculation cycle of samples, then the evaluation time of the stage.
   task automatic ev(input logic signed [15:0] d, input logic signed [15:0] a,
      input logic signed [15:0] h);
      int n;
      n = 0;
      @(posedge sys_clk);
      dc <= d;
      amp <= a;
      hamp <= h;
      burst <= 1'b1;
      @(posedge sys_clk);
      burst <= 1'b0;
      @(negedge sys_clk);
      while (busy !== 1'b0 && n < 1000)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 1000)
         hang("samples");
      repeat (300) @(negedge sys_clk);
   endtask : ev
   function automatic logic near(input logic [15:0] v, input int e);
      return v >= e - 100 && v <= e + 100;
   endfunction : near
   // Offset sine well above threshold in every magnitude mode.
   task automatic recover();
      ev(16'sh1388, 16'sh1388, 16'sh0000);
      `CHK("start_clear", 1'b0, start)
      `CHK("operate_clear", 1'b0, operate)
   endtask : recover
   task automatic trip_at(input int k, input logic signed [15:0] v);
      for (int i = 1; i <= k; i++)
      begin
         ev(v, 16'sh0000, 16'sh0000);
         `CHK("start_held", 1'b1, start)
         `CHK("operate_time", (i == k), operate)
      end
   endtask : trip_at
   task automatic t_regs();
      logic [31:0] ex[12] = '{32'h11, 32'h4000, 32'h0100, 32'h0, 32'h0200, 32'h10000,
         32'h10000, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
      for (int i = 0; i < 12; i++)
      begin
         rd(6'(4 * i));
         `CHK("reg_reset", ex[i], rdata)
      end
      wr(6'h2c, 32'hffffffff);
      rd(6'h2c);
      `CHK("unmapped", 32'h00000000, rdata)
      bus(1'b1, 6'h04, 32'h000012ab, 4'h1);
      rd(6'h04);
      `CHK("thr_lane", 32'h000040ab, rdata)
      $display("test regs done");
   endtask : t_regs
   task automatic t_modes();
      wr(6'h04, 32'h00001000);
      wr(6'h00, 32'h00000010);
      ev(16'sh0bb8, 16'sh0000, 16'sh0000);
      `CHK("rms_start", 1'b1, start)
      rd(6'h28);
      `CHK("rms_mag", 16'h0bb8, rdata[31:16])
      ev(-16'sh1388, 16'sh0000, 16'sh0000);
      `CHK("rms_dc_kept", 1'b0, start)
      wr(6'h00, 32'h00000012);
      ev(16'sh1388, 16'sh0000, 16'sh0000);
      `CHK("pp_dc_excl", 1'b1, start)
      ev(16'sh0000, 16'sh1388, 16'sh0000);
      rd(6'h28);
      `CHK("pp_mag", 1'b1, near(rdata[31:16], 5000))
      wr(6'h00, 32'h00000011);
      ev(16'sh0000, 16'sh0bb8, 16'sh07d0);
      rd(6'h28);
      `CHK("dft_mag", 1'b1, near(rdata[31:16], 3000))
      `CHK("dft_start", 1'b1, start)
      recover();
      $display("test modes done");
   endtask : t_modes
   task automatic t_std_curves();
      wr(6'h00, 32'h00000010);
      wr(6'h08, 32'h00000020);
      trip_at(7, 16'sh0000);
      recover();
      wr(6'h00, 32'h00000014);
      wr(6'h08, 32'h00000040);
      trip_at(9, 16'sh0000);
      recover();
      wr(6'h00, 32'h00000010);
      wr(6'h08, 32'h00000001);
      wr(6'h0c, 32'h00001900);
      trip_at(5, 16'sh0000);
      recover();
      wr(6'h0c, 32'h00000000);
      wr(6'h10, 32'h00000a00);
      trip_at(4, 16'sh0f33);
      recover();
      $display("test standard curves done");
   endtask : t_std_curves
   task automatic t_user_curve();
      logic [31:0] cf[5] = '{32'h0e00, 32'h10000, 32'h0, 32'h0, 32'h1};
      for (int i = 0; i < 5; i++)
         wr(6'(8'h14 + 4 * i), cf[i]);
      wr(6'h00, 32'h00000018);
      wr(6'h08, 32'h00000020);
      trip_at(4, 16'sh0f33);
      recover();
      $display("test user curve done");
   endtask : t_user_curve
   task automatic t_fallback();
      logic [31:0] cw[3] = '{32'h33, 32'h72, 32'h73};
      wr(6'h0c, 32'h00100000);
      for (int i = 0; i < 3; i++)
      begin
         wr(6'h00, cw[i]);
         ev(16'sh0000, 16'sh2710, 16'sh0000);
         `CHK("peak_fallback", (i == 2), start)
      end
      $display("test fallback done");
   endtask : t_fallback
   task automatic t_reset();
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      `CHK("rst_start", 1'b0, start)
      `CHK("rst_operate", 1'b0, operate)
      rd(6'h00);
      `CHK("rst_ctrl", 32'h00000011, rdata)
      $display("test reset done");
   endtask : t_reset
   initial
   begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_regs();
      t_modes();
      t_std_curves();
      t_user_curve();
      t_fallback();
      t_reset();
      tally_and_finish();
   end
endmodule : uvidmt_stage_tb
`default_nettype wire
